// ---- hw/pubsub_submsg_flags_ports.v ----
// submessage flag decoder, default udp port generator and announcement timer
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pubsub_map.vh"
module pubsub_submsg_flags_ports #(
	parameter [31:0] ANNOUNCE_CYCLES = `ANNOUNCE_SEC * (`NS_PER_SEC / `CLK_PERIOD_NS)
) (
	input wire aclk, // system clock, 25 MHz
	input wire aresetn, // synchronous reset, active low
	input wire [7:0] awaddr, // write address
	input wire awvalid, // write address valid
	output reg awready, // write address ready
	input wire [31:0] wdata, // write data
	input wire [3:0] wstrb, // write byte enables
	input wire wvalid, // write data valid
	output reg wready, // write data ready
	output reg [1:0] bresp, // write response
	output reg bvalid, // write response valid
	input wire bready, // write response ready
	input wire [7:0] araddr, // read address
	input wire arvalid, // read address valid
	output reg arready, // read address ready
	output reg [31:0] rdata, // read data
	output reg [1:0] rresp, // read response
	output reg rvalid, // read data valid
	input wire rready, // read data ready
	output reg announce_pulse, // one cycle per announcement period
	output wire [15:0] disc_mcast_port, // discovery multicast port
	output reg cfg_invalid // some port expression overflows
);

// ----------------------------------------
// settings and state
// ----------------------------------------
reg [15:0] port_base_number;
reg [15:0] domain_id_gain;
reg [15:0] participant_id_gain;
reg [15:0] discovery_mcast_offset;
reg [15:0] discovery_ucast_offset;
reg [15:0] user_mcast_offset;
reg [15:0] user_ucast_offset;
reg [7:0] domain_id;
reg [7:0] participant_id;
reg [6:0] decode_status;
reg ts_valid;
reg announce_enable;
reg [31:0] announce_timer;
reg [31:0] announce_count;
reg aw_held;
reg w_held;
reg [7:0] aw_addr_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;
reg [31:0] read_word;
reg read_ok;
reg write_ok;
wire [15:0] disc_ucast_port;
wire [15:0] user_mcast_port;
wire [15:0] user_ucast_port;
wire [3:0] port_overflow;
wire do_write;
wire [31:0] merged;
wire [7:0] sub_kind;
wire [7:0] sub_flags;
assign do_write = aw_held && w_held && !bvalid;
assign sub_kind = w_data_q[`SUB_KIND_LSB +: 8];
assign sub_flags = w_data_q[`SUB_FLAGS_LSB +: 8];

// byte lanes not enabled keep the old value of the target word
function [31:0] merge;
	input [31:0] old;
	input [31:0] data;
	input [3:0] strb;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (strb[i])
				merge[i*8 +: 8] = data[i*8 +: 8];
		end
	end
endfunction

// ----------------------------------------
// port expressions
// ----------------------------------------
// discovery multicast port
port_calc #(.USE_PID(0)) calc_disc_mc (.aclk(aclk), .aresetn(aresetn), .base(port_base_number),
	.dom_gain(domain_id_gain), .pid_gain(participant_id_gain), .offset(discovery_mcast_offset),
	.domain_id(domain_id), .participant_id(participant_id), .port(disc_mcast_port), .overflow(port_overflow[0]));
port_calc #(.USE_PID(1)) calc_disc_uc (.aclk(aclk), .aresetn(aresetn), .base(port_base_number),
	.dom_gain(domain_id_gain), .pid_gain(participant_id_gain), .offset(discovery_ucast_offset),
	.domain_id(domain_id), .participant_id(participant_id), .port(disc_ucast_port), .overflow(port_overflow[1]));
port_calc #(.USE_PID(0)) calc_user_mc (.aclk(aclk), .aresetn(aresetn), .base(port_base_number),
	.dom_gain(domain_id_gain), .pid_gain(participant_id_gain), .offset(user_mcast_offset),
	.domain_id(domain_id), .participant_id(participant_id), .port(user_mcast_port), .overflow(port_overflow[2]));
port_calc #(.USE_PID(1)) calc_user_uc (.aclk(aclk), .aresetn(aresetn), .base(port_base_number),
	.dom_gain(domain_id_gain), .pid_gain(participant_id_gain), .offset(user_ucast_offset),
	.domain_id(domain_id), .participant_id(participant_id), .port(user_ucast_port), .overflow(port_overflow[3]));

// any overflow marks the configuration invalid
always @(posedge aclk) begin
	if (!aresetn) begin
		cfg_invalid <= 1'b0;
	end else begin
		cfg_invalid <= |port_overflow;
	end
end

// ----------------------------------------
// bus write channels
// ----------------------------------------
// address and data are caught independently, so either may come first
always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held <= 1'b0;
		awready <= 1'b0;
		aw_addr_q <= 8'h00;
		w_held <= 1'b0;
		wready <= 1'b0;
		w_data_q <= 32'h0000_0000;
		w_strb_q <= 4'h0;
		bvalid <= 1'b0;
		bresp <= `RESP_OKAY;
	end else begin
		if (awvalid && awready) begin
			aw_held <= 1'b1;
			awready <= 1'b0;
			aw_addr_q <= awaddr;
		end else if (do_write || !aw_held) begin
			aw_held <= 1'b0;
			awready <= 1'b1;
		end
		if (wvalid && wready) begin
			w_held <= 1'b1;
			wready <= 1'b0;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (do_write || !w_held) begin
			w_held <= 1'b0;
			wready <= 1'b1;
		end
		if (do_write) begin
			bvalid <= 1'b1;
			bresp <= write_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end
end

// read-only words accept writes silently; only holes answer with an error
always @* begin
	write_ok = 1'b1;
	if (aw_addr_q > `ADDR_ANN_PERIOD) begin
		write_ok = 1'b0;
	end else if (aw_addr_q[1:0] != 2'b00) begin
		write_ok = 1'b0;
	end
end

// ----------------------------------------
// settings registers
// ----------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		port_base_number <= `RST_PORT_BASE;
		domain_id_gain <= `RST_DOM_GAIN;
		participant_id_gain <= `RST_PID_GAIN;
		discovery_mcast_offset <= `RST_DISC_MC_OFS;
		discovery_ucast_offset <= `RST_DISC_UC_OFS;
		user_mcast_offset <= `RST_USER_MC_OFS;
		user_ucast_offset <= `RST_USER_UC_OFS;
		domain_id <= 8'h00;
		participant_id <= 8'h00;
		announce_enable <= 1'b1;
	end else if (do_write) begin
		// every expression term is software writable
		if (aw_addr_q == `ADDR_PORT_BASE) begin
			port_base_number <= merged[15:0];
		end else if (aw_addr_q == `ADDR_DOM_GAIN) begin
			domain_id_gain <= merged[15:0];
		end else if (aw_addr_q == `ADDR_PID_GAIN) begin
			participant_id_gain <= merged[15:0];
		end else if (aw_addr_q == `ADDR_DISC_MC_OFS) begin
			discovery_mcast_offset <= merged[15:0];
		end else if (aw_addr_q == `ADDR_DISC_UC_OFS) begin
			discovery_ucast_offset <= merged[15:0];
		end else if (aw_addr_q == `ADDR_USER_MC_OFS) begin
			user_mcast_offset <= merged[15:0];
		end else if (aw_addr_q == `ADDR_USER_UC_OFS) begin
			user_ucast_offset <= merged[15:0];
		end else if (aw_addr_q == `ADDR_IDS) begin
			// software gives each local participant its own id
			domain_id <= merged[`IDS_DOM_LSB +: 8];
			participant_id <= merged[`IDS_PID_LSB +: 8];
		end else if (aw_addr_q == `ADDR_ANN_CTRL) begin
			announce_enable <= merged[0];
		end
	end
end

assign merged = merge(32'h0000_0000 | read_back(aw_addr_q), w_data_q, w_strb_q);

function [31:0] read_back;
	input [7:0] a;
	begin
		read_back = 32'h0000_0000;
		if (a == `ADDR_PORT_BASE) begin
			read_back[15:0] = port_base_number;
		end else if (a == `ADDR_DOM_GAIN) begin
			read_back[15:0] = domain_id_gain;
		end else if (a == `ADDR_PID_GAIN) begin
			read_back[15:0] = participant_id_gain;
		end else if (a == `ADDR_DISC_MC_OFS) begin
			read_back[15:0] = discovery_mcast_offset;
		end else if (a == `ADDR_DISC_UC_OFS) begin
			read_back[15:0] = discovery_ucast_offset;
		end else if (a == `ADDR_USER_MC_OFS) begin
			read_back[15:0] = user_mcast_offset;
		end else if (a == `ADDR_USER_UC_OFS) begin
			read_back[15:0] = user_ucast_offset;
		end else if (a == `ADDR_IDS) begin
			read_back[`IDS_DOM_LSB +: 8] = domain_id;
			read_back[`IDS_PID_LSB +: 8] = participant_id;
		end else if (a == `ADDR_ANN_CTRL) begin
			read_back[0] = announce_enable;
		end
	end
endfunction

// ----------------------------------------
// submessage header decode
// ----------------------------------------
// a submessage word carries full bytes, so byte enables are not applied here
always @(posedge aclk) begin
	if (!aresetn) begin
		decode_status <= 7'h00;
		ts_valid <= 1'b0;
	end else if (do_write && aw_addr_q == `ADDR_SUBMSG) begin
		decode_status <= 7'h00;
		decode_status[`DEC_ENDIAN] <= |(sub_flags & `FLAG_ENDIAN);
		decode_status[`DEC_KNOWN] <= 1'b1;
		decode_status[`DEC_TS_VALID] <= ts_valid;
		if (sub_kind == `KIND_REPLY) begin
			// multicast list follows the unicast list
			decode_status[`DEC_REPLY] <= 1'b1;
			decode_status[`DEC_MCAST] <= |(sub_flags & `FLAG_MCAST);
		end else if (sub_kind == `KIND_REPLY_IP4) begin
			// compact form seen as a reply-info
			decode_status[`DEC_REPLY] <= 1'b1;
			decode_status[`DEC_COMPACT] <= 1'b1;
			decode_status[`DEC_MCAST] <= |(sub_flags & `FLAG_MCAST);
		end else if (sub_kind == `KIND_TS) begin
			// invalidate carries no timestamp and poisons what follows
			decode_status[`DEC_TS_PRESENT] <= ~|(sub_flags & `FLAG_INVAL);
			decode_status[`DEC_TS_VALID] <= ~|(sub_flags & `FLAG_INVAL);
			ts_valid <= ~|(sub_flags & `FLAG_INVAL);
		end else if (sub_kind == `KIND_DST || sub_kind == `KIND_SRC || sub_kind == `KIND_PAD ||
				sub_kind == `KIND_NACKFRAG) begin
			// no flag besides endianness is looked at
			decode_status[`DEC_KNOWN] <= 1'b1;
		end else begin
			decode_status[`DEC_KNOWN] <= 1'b0;
		end
		// a new datagram starts a new message with no timestamp
		if (w_data_q[`SUB_NEWMSG_BIT] && sub_kind != `KIND_TS) begin
			ts_valid <= 1'b0;
			decode_status[`DEC_TS_VALID] <= 1'b0;
		end
	end
end

// ----------------------------------------
// announcement period
// ----------------------------------------
// free-running period, restarted whenever announcing is disabled
always @(posedge aclk) begin
	if (!aresetn) begin
		announce_timer <= 32'h0000_0000;
		announce_count <= 32'h0000_0000;
		announce_pulse <= 1'b0;
	end else if (!announce_enable) begin
		announce_timer <= 32'h0000_0000;
		announce_pulse <= 1'b0;
	end else if (announce_timer == ANNOUNCE_CYCLES - 32'h0000_0001) begin
		announce_timer <= 32'h0000_0000;
		announce_count <= announce_count + 32'h0000_0001;
		announce_pulse <= 1'b1;
	end else begin
		announce_timer <= announce_timer + 32'h0000_0001;
		announce_pulse <= 1'b0;
	end
end

// ----------------------------------------
// bus read channel
// ----------------------------------------
always @* begin
	read_word = 32'h0000_0000;
	read_ok = 1'b1;
	if (araddr[1:0] != 2'b00) begin
		read_ok = 1'b0;
	end else if (araddr <= `ADDR_IDS || araddr == `ADDR_ANN_CTRL || araddr == `ADDR_SUBMSG) begin
		read_word = read_back(araddr);
	end else if (araddr == `ADDR_DISC_PORTS) begin
		// endpoint discovery uses these same ports
		read_word = {disc_ucast_port, disc_mcast_port};
	end else if (araddr == `ADDR_USER_PORTS) begin
		read_word = {user_ucast_port, user_mcast_port};
	end else if (araddr == `ADDR_CFG_STATUS) begin
		read_word = {27'h000_0000, port_overflow, cfg_invalid};
	end else if (araddr == `ADDR_DECODE) begin
		read_word = {25'h000_0000, decode_status};
	end else if (araddr == `ADDR_ANN_COUNT) begin
		read_word = announce_count;
	end else if (araddr == `ADDR_MC_GROUP) begin
		// announce and listen group, port is the discovery multicast one
		read_word = `MC_GROUP_ADDR;
	end else if (araddr == `ADDR_ANN_PERIOD) begin
		read_word = `ANNOUNCE_SEC | `ANNOUNCE_FRAC;
	end else begin
		read_ok = 1'b0;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		arready <= 1'b0;
		rvalid <= 1'b0;
		rdata <= 32'h0000_0000;
		rresp <= `RESP_OKAY;
	end else if (arvalid && arready) begin
		arready <= 1'b0;
		rvalid <= 1'b1;
		rdata <= read_word;
		rresp <= read_ok ? `RESP_OKAY : `RESP_SLVERR;
	end else if (rvalid && rready) begin
		rvalid <= 1'b0;
		arready <= 1'b1;
	end else if (!rvalid) begin
		arready <= 1'b1;
	end
end

endmodule

// ---- hw/pubsub_map.vh ----
// register map, reset values and protocol constants of the submessage flag and port block
`ifndef PUBSUB_MAP_VH
`define PUBSUB_MAP_VH

// register byte addresses
`define ADDR_PORT_BASE 8'h00
`define ADDR_DOM_GAIN 8'h04
`define ADDR_PID_GAIN 8'h08
`define ADDR_DISC_MC_OFS 8'h0c
`define ADDR_DISC_UC_OFS 8'h10
`define ADDR_USER_MC_OFS 8'h14
`define ADDR_USER_UC_OFS 8'h18
`define ADDR_IDS 8'h1c
`define ADDR_DISC_PORTS 8'h20
`define ADDR_USER_PORTS 8'h24
`define ADDR_CFG_STATUS 8'h28
`define ADDR_SUBMSG 8'h2c
`define ADDR_DECODE 8'h30
`define ADDR_ANN_CTRL 8'h34
`define ADDR_ANN_COUNT 8'h38
`define ADDR_MC_GROUP 8'h3c
`define ADDR_ANN_PERIOD 8'h40

// reset values: 7400, 250, 2, 0, 10, 1, 11
`define RST_PORT_BASE 16'h1ce8
`define RST_DOM_GAIN 16'h00fa
`define RST_PID_GAIN 16'h0002
`define RST_DISC_MC_OFS 16'h0000
`define RST_DISC_UC_OFS 16'h000a
`define RST_USER_MC_OFS 16'h0001
`define RST_USER_UC_OFS 16'h000b

// field positions
`define IDS_DOM_LSB 0
`define IDS_PID_LSB 8
`define SUB_KIND_LSB 0
`define SUB_FLAGS_LSB 8
`define SUB_NEWMSG_BIT 16
`define DEC_KNOWN 0
`define DEC_ENDIAN 1
`define DEC_REPLY 2
`define DEC_MCAST 3
`define DEC_TS_PRESENT 4
`define DEC_TS_VALID 5
`define DEC_COMPACT 6

// submessage kinds
`define KIND_DST 8'h01
`define KIND_REPLY 8'h02
`define KIND_REPLY_IP4 8'h03
`define KIND_SRC 8'h04
`define KIND_TS 8'h05
`define KIND_PAD 8'h06
`define KIND_NACKFRAG 8'h07

// header flag masks
`define FLAG_ENDIAN 8'h01
`define FLAG_MCAST 8'h02
`define FLAG_INVAL 8'h02

// default discovery group 239.255.0.1
`define MC_GROUP_ADDR 32'hefff_0001

// announcement timing: 30 s, zero fraction, clock period 40 ns
`define ANNOUNCE_SEC 32'h0000_001e
`define ANNOUNCE_FRAC 32'h0000_0000
`define NS_PER_SEC 32'h3b9a_ca00
`define CLK_PERIOD_NS 32'h0000_0028

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- hw/port_calc.v ----
// one registered udp port number expression with overflow check
`timescale 1ns/1ps
module port_calc #(
	parameter USE_PID = 0
) (
	input wire aclk, // system clock
	input wire aresetn, // synchronous reset, active low
	input wire [15:0] base, // port base number
	input wire [15:0] dom_gain, // domain id gain
	input wire [15:0] pid_gain, // participant id gain
	input wire [15:0] offset, // additional offset
	input wire [7:0] domain_id, // domain identifier
	input wire [7:0] participant_id, // participant identifier
	output reg [15:0] port, // resulting port number
	output reg overflow // result does not fit 16 bits
);

wire [23:0] dom_term;
wire [23:0] pid_term;
wire [25:0] sum;

assign dom_term = dom_gain * domain_id;
// multicast instances leave the participant term out entirely
assign pid_term = (USE_PID != 0) ? pid_gain * participant_id : 24'h00_0000;
// unsigned sum wide enough that no term can wrap before the check
assign sum = {10'h000, base} + {2'h0, dom_term} + {10'h000, offset} + {2'h0, pid_term};

always @(posedge aclk) begin
	if (!aresetn) begin
		port <= 16'h0000;
		overflow <= 1'b0;
	end else begin
		port <= sum[15:0];
		overflow <= |sum[25:16];
	end
end

endmodule

// ---- tb/pubsub_flags_monitor.sv ----
// checker of bus answers, port updates and announcement spacing
`timescale 1ns/1ps
module pubsub_flags_monitor #(
	parameter [31:0] ANNOUNCE_CYCLES = 32'h0000_0014
) (
	input wire aclk, // system clock
	input wire aresetn, // sync reset, active low
	input wire awvalid, // write address valid
	input wire awready, // write address ready
	input wire wvalid, // write data valid
	input wire wready, // write data ready
	input wire bvalid, // write response valid
	input wire bready, // write response ready
	input wire arvalid, // read address valid
	input wire arready, // read address ready
	input wire rvalid, // read data valid
	input wire rready, // read data ready
	input wire announce_pulse, // announcement strobe
	input wire [15:0] disc_mcast_port, // discovery multicast port
	input wire cfg_invalid // overflow flag
);
	// cycles since the last announcement; enable off only makes gaps longer
	reg [31:0] gap;
	reg seen;
	always @(posedge aclk) begin
		if (!aresetn) begin
			gap <= 32'h0000_0000;
			seen <= 1'b0;
		end else if (announce_pulse) begin
			gap <= 32'h0000_0000;
			seen <= 1'b1;
		end else begin
			gap <= gap + 32'h0000_0001;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_wr_answer;
		!awready ##1 bvalid;
	endsequence
	AST_WR_ANSWER: assert property (s_wr_taken |=> s_wr_answer)
		else $error("write response late");
	AST_B_DONE: assert property (bvalid && bready |=> !bvalid)
		else $error("write response not released");
	AST_AR_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read data late");
	AST_R_DONE: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read data not released");
	AST_ANN_PULSE: assert property (announce_pulse |=> !announce_pulse [*8])
		else $error("announcement strobe too long");
	AST_ANN_GAP: assert property (announce_pulse && seen |-> gap >= ANNOUNCE_CYCLES - 1)
		else $error("announcements too close");
	AST_PORT_CAUSE: assert property ($changed(disc_mcast_port) && $past(aresetn, 2) |->
		$past(bvalid, 1) || $past(bvalid, 2) || $past(bvalid, 3))
		else $error("discovery port moved without a write");
	AST_CFG_CAUSE: assert property ($changed(cfg_invalid) |->
		$past(bvalid, 2) || $past(bvalid, 3) || $past(bvalid, 4))
		else $error("overflow flag moved without a write");
endmodule
bind pubsub_submsg_flags_ports pubsub_flags_monitor #(.ANNOUNCE_CYCLES(ANNOUNCE_CYCLES)) mon (.aclk(aclk),
	.aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
	.announce_pulse(announce_pulse), .disc_mcast_port(disc_mcast_port), .cfg_invalid(cfg_invalid));

// ---- tb/remote_participant.sv ----
// far-side participant counting the announcements it hears on the group port
`timescale 1ns/1ps
module remote_participant (
	input wire aclk, // system clock
	input wire aresetn, // sync reset, active low
	input wire announce_pulse, // one announcement datagram
	input wire [15:0] disc_mcast_port, // group port it is sent to
	output reg [15:0] heard, // announcements received
	output reg [15:0] heard_port // port of the last one
);
	always @(posedge aclk) begin
		if (!aresetn) begin
			heard <= 16'h0000;
			heard_port <= 16'h0000;
		end else if (announce_pulse) begin
			heard <= heard + 16'h0001;
			heard_port <= disc_mcast_port;
		end
	end
endmodule

// ---- tb/pubsub_submsg_flags_ports_test.sv ----
// testbench of the submessage flag decoder and port generator
`timescale 1ns/1ps
`include "pubsub_map.vh"
module pubsub_submsg_flags_ports_test;
	// short period keeps the run small
	localparam [31:0] PERIOD = 32'h0000_0014;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hf;
	wire awready, wready, bvalid, arready, rvalid, announce_pulse, cfg_invalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] disc_mcast_port, heard, heard_port;
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	logic [15:0] dflt [7] = '{16'h1ce8, 16'h00fa, 16'h0002, 16'h0000, 16'h000a, 16'h0001, 16'h000b};
	logic [15:0] st [7];
	logic [1:0] r;
	logic [31:0] d;
	pubsub_submsg_flags_ports #(.ANNOUNCE_CYCLES(PERIOD)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .announce_pulse(announce_pulse),
		.disc_mcast_port(disc_mcast_port), .cfg_invalid(cfg_invalid));
	remote_participant peer (.aclk(aclk), .aresetn(aresetn), .announce_pulse(announce_pulse),
		.disc_mcast_port(disc_mcast_port), .heard(heard), .heard_port(heard_port));
	always #20 aclk = ~aclk;
	// ----------------------------------------
	// bus tasks and comparison
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		while (!bvalid) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic set_all;
		for (int i = 0; i < 7; i++) begin
			wr(8'(4 * i), {16'h0000, st[i]});
			chk("setting response", r, `RESP_OKAY);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults;
		for (int i = 0; i < 7; i++) begin
			rd(8'(4 * i));
			chk("setting", d, {16'h0000, st[i]});
		end
		rd(`ADDR_MC_GROUP);
		chk("group", d, 32'hefff_0001);
		rd(`ADDR_ANN_PERIOD);
		chk("period", d, 32'h0000_001e);
	endtask
	task automatic t_ports(input logic [7:0] dom, input logic [7:0] pid);
		logic [25:0] b, m;
		logic [25:0] s [4];
		logic [3:0] ov;
		wr(`ADDR_IDS, {16'h0000, pid, dom});
		b = st[0] + st[1] * dom;
		m = st[2] * pid;
		s[0] = b + st[3];
		s[1] = b + st[4] + m;
		s[2] = b + st[5];
		s[3] = b + st[6] + m;
		ov = {|s[3][25:16], |s[2][25:16], |s[1][25:16], |s[0][25:16]};
		rd(`ADDR_DISC_PORTS);
		chk("discovery ports", d, {s[1][15:0], s[0][15:0]});
		rd(`ADDR_USER_PORTS);
		chk("user ports", d, {s[3][15:0], s[2][15:0]});
		chk("multicast pin", disc_mcast_port, s[0][15:0]);
		rd(`ADDR_CFG_STATUS);
		chk("overflow", {d[4:0], cfg_invalid}, {ov, |ov, |ov});
	endtask
	task automatic t_decode;
		// a valid timestamp context is set, then invalidated, then set again and cut by a new datagram
		logic [31:0] sub [12] = '{32'h0000_0005, 32'h0000_0202, 32'h0001_0205, 32'h0000_0303, 32'h0000_0005,
			32'h0001_ff01, 32'h0000_fe04, 32'h0000_0306, 32'h0000_0207, 32'h0000_0309, 32'h0000_0002, 32'h0000_0003};
		logic [7:0] dec [12] = '{8'h31, 8'h2d, 8'h01, 8'h4f, 8'h31, 8'h03, 8'h01, 8'h03, 8'h01, 8'h02, 8'h05, 8'h45};
		for (int i = 0; i < 12; i++) begin
			wr(`ADDR_SUBMSG, sub[i]);
			rd(`ADDR_DECODE);
			chk("decode", d, {24'h00_0000, dec[i]});
		end
	endtask
	task automatic t_announce;
		logic [31:0] c0;
		wr(`ADDR_ANN_CTRL, 32'h0000_0000);
		rd(`ADDR_ANN_COUNT);
		c0 = d;
		chk("count vs peer", d, {16'h0000, heard});
		chk("announced port", heard_port, 16'h1ce8);
		wr(`ADDR_ANN_CTRL, 32'h0000_0001);
		repeat (3 * PERIOD + 10) @(posedge aclk);
		wr(`ADDR_ANN_CTRL, 32'h0000_0000);
		repeat (2 * PERIOD) @(posedge aclk);
		rd(`ADDR_ANN_COUNT);
		chk("count", d, c0 + 32'h0000_0003);
		chk("peer count", heard, c0[15:0] + 16'h0003);
	endtask
	task automatic t_refused;
		rd(8'h44);
		chk("far read", r, `RESP_SLVERR);
		rd(8'h02);
		chk("unaligned read", r, `RESP_SLVERR);
		wr(8'h48, 32'h0000_1234);
		chk("far write", r, `RESP_SLVERR);
		wr(`ADDR_MC_GROUP, 32'h0000_0000);
		rd(`ADDR_MC_GROUP);
		chk("group read only", d, 32'hefff_0001);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			report_and_stop;
		end
	end
	initial begin
		st = dflt;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_defaults;
		t_ports(8'h00, 8'h00);
		t_ports(8'h03, 8'h01);
		t_ports(8'h03, 8'h02);
		st = '{16'h1000, 16'h0064, 16'h0003, 16'h0005, 16'h0006, 16'h0007, 16'h0008};
		set_all;
		t_ports(8'h03, 8'h01);
		st[0] = 16'hffff;
		set_all;
		t_ports(8'h00, 8'h00);
		st = dflt;
		set_all;
		t_ports(8'h00, 8'h00);
		t_decode;
		t_announce;
		t_refused;
		report_and_stop;
	end
endmodule
